// *** design/csr_core_regs.sv ***
// special register bank of a core: pin outputs, launch parameter, phases
// ---------------------------------------------------------------------------
// module
// ---------------------------------------------------------------------------
// Contract
// - launched code is written into core RAM starting at address zero.
// - pin output register holds one driven level per pin, 32 pins.
// - output pin drives low for bit 0, high for bit 1.
// - pin output register readable/writable both operands; whole word unless masked.
// - second port output register is reserved: reads zero, writes ignored.
// - launch parameter holds the address value supplied at launch.
// - launch parameter keeps bits 2 to 15, low two bits forced zero.
// - launch parameter as source returns launch value; it is read-only.
// - launch parameter address as destination touches only its shadow.
// - phase registers are read/write, acting differently per operand slot.
// - source reads live accumulator; destination reads shadow; writes update both.
// - each accumulator adds its increment value when its counter steps, unless a write to it lands in the same cycle.
module csr_core_regs #(
  parameter int LOAD_WORDS = csr_pkg::LOAD_WORDS_DEF
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire csr_pkg::csr_op_t i_op,
  output csr_pkg::csr_rd_t o_rd,
  input wire logic i_launch,
  input wire logic [csr_pkg::LAUNCH_IN_W-1:0] i_launch_param,
  input wire logic i_load_valid,
  input wire logic [csr_pkg::DATA_W-1:0] i_load_word,
  output logic o_load_ready,
  output csr_pkg::csr_ram_wr_t o_ram_wr,
  output logic o_core_run,
  input wire logic [csr_pkg::DATA_W-1:0] i_pin_dir,
  output logic [csr_pkg::DATA_W-1:0] o_pin_level,
  output logic [csr_pkg::DATA_W-1:0] o_pin_oe,
  input wire logic i_ctr_a_step,
  input wire logic [csr_pkg::DATA_W-1:0] i_counter_a_increment,
  input wire logic i_ctr_b_step,
  input wire logic [csr_pkg::DATA_W-1:0] i_counter_b_increment
);
  import csr_pkg::*;

  // ---------------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------------
  if (LOAD_WORDS < 1 || LOAD_WORDS > (1 << ADDR_W)) begin : g_bad_len
    $error("LOAD_WORDS must lie between 1 and the RAM size");
  end

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  logic [DATA_W-1:0] pin_output_levels_q;
  logic [DATA_W-1:0] launch_parameter_q;
  logic [DATA_W-1:0] launch_shadow_q;
  logic [DATA_W-1:0] phase_q [2];
  logic [DATA_W-1:0] phase_shadow_q [2];
  logic [DATA_W-1:0] phase_d [2];
  logic [DATA_W-1:0] increment [2];
  logic step [2];
  logic [ADDR_W-1:0] phase_addr [2];
  csr_load_state_t load_state_q;
  logic [ADDR_W-1:0] load_addr_q;
  csr_ram_wr_t ram_wr_q;
  logic core_run_q;
  csr_rd_t rd_q;
  logic load_last;

  // masked merge: an ordinary instruction gives an all-ones mask, a
  // mux-type one gives only its selected bits
  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old_v,
    input logic [DATA_W-1:0] new_v,
    input logic [DATA_W-1:0] mask
  );
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  // ---------------------------------------------------------------------
  // pin output register and pin drive
  // ---------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_output_levels_q <= RST_WORD;
    end else if (i_op.wr_en && i_op.wr_addr == ADDR_PIN_OUTPUT_LEVELS) begin
      pin_output_levels_q <= merge(pin_output_levels_q, i_op.wr_data,
                                   i_op.wr_mask);
    end
  end

  // level only matters where the direction makes the pin an output
  assign o_pin_level = pin_output_levels_q;
  assign o_pin_oe = i_pin_dir;

  // ---------------------------------------------------------------------
  // launch parameter and its shadow
  // ---------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      launch_parameter_q <= RST_WORD;
    end else if (i_launch) begin
      launch_parameter_q <= RST_WORD;
      launch_parameter_q[LAUNCH_KEEP_HI:LAUNCH_KEEP_LO] <=
        i_launch_param[LAUNCH_KEEP_HI:LAUNCH_KEEP_LO];
    end
  end

  // operand writes never reach the launch value, only the shadow word
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      launch_shadow_q <= RST_WORD;
    end else if (i_op.wr_en && i_op.wr_addr == ADDR_LAUNCH_PARAMETER) begin
      launch_shadow_q <= merge(launch_shadow_q, i_op.wr_data,
                               i_op.wr_mask);
    end
  end

  // ---------------------------------------------------------------------
  // counter phase accumulators, one per counter
  // ---------------------------------------------------------------------
  assign increment[0] = i_counter_a_increment;
  assign increment[1] = i_counter_b_increment;
  assign step[0] = i_ctr_a_step;
  assign step[1] = i_ctr_b_step;
  assign phase_addr[0] = ADDR_COUNTER_A_PHASE;
  assign phase_addr[1] = ADDR_COUNTER_B_PHASE;

  for (genvar c = 0; c < 2; c++) begin : g_phase
    // a write in the same cycle as a step wins; the step is dropped
    always_comb begin
      if (i_op.wr_en && i_op.wr_addr == phase_addr[c]) begin
        phase_d[c] = merge(phase_shadow_q[c], i_op.wr_data,
                           i_op.wr_mask);
      end else if (step[c]) begin
        phase_d[c] = phase_q[c] + increment[c];
      end else begin
        phase_d[c] = phase_q[c];
      end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
        phase_q[c] <= RST_WORD;
      end else begin
        phase_q[c] <= phase_d[c];
      end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
        phase_shadow_q[c] <= RST_WORD;
      end else if (i_op.wr_en && i_op.wr_addr == phase_addr[c]) begin
        phase_shadow_q[c] <= phase_d[c];
      end
    end
  end

  // ---------------------------------------------------------------------
  // operand read path, answered one cycle after the request
  // ---------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_q.src_hit <= 1'b0;
      rd_q.src_data <= RST_WORD;
    end else begin
      rd_q.src_hit <= 1'b1;
      if (i_op.src_addr == ADDR_PIN_OUTPUT_LEVELS) begin
        rd_q.src_data <= pin_output_levels_q;
      end else if (i_op.src_addr == ADDR_LAUNCH_PARAMETER) begin
        rd_q.src_data <= launch_parameter_q;
      end else if (i_op.src_addr == ADDR_SECOND_PORT_OUTPUT) begin
        rd_q.src_data <= RST_WORD;
      end else if (i_op.src_addr == ADDR_COUNTER_A_PHASE) begin
        rd_q.src_data <= phase_q[0];
      end else if (i_op.src_addr == ADDR_COUNTER_B_PHASE) begin
        rd_q.src_data <= phase_q[1];
      end else begin
        rd_q.src_hit <= 1'b0;
        rd_q.src_data <= RST_WORD;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_q.dst_hit <= 1'b0;
      rd_q.dst_data <= RST_WORD;
    end else begin
      rd_q.dst_hit <= 1'b1;
      if (i_op.dst_addr == ADDR_PIN_OUTPUT_LEVELS) begin
        rd_q.dst_data <= pin_output_levels_q;
      end else if (i_op.dst_addr == ADDR_LAUNCH_PARAMETER) begin
        rd_q.dst_data <= launch_shadow_q;
      end else if (i_op.dst_addr == ADDR_SECOND_PORT_OUTPUT) begin
        rd_q.dst_data <= RST_WORD;
      end else if (i_op.dst_addr == ADDR_COUNTER_A_PHASE) begin
        rd_q.dst_data <= phase_shadow_q[0];
      end else if (i_op.dst_addr == ADDR_COUNTER_B_PHASE) begin
        rd_q.dst_data <= phase_shadow_q[1];
      end else begin
        rd_q.dst_hit <= 1'b0;
        rd_q.dst_data <= RST_WORD;
      end
    end
  end

  assign o_rd = rd_q;

  // ---------------------------------------------------------------------
  // launch loader: code always lands from RAM address zero upward
  // ---------------------------------------------------------------------
  assign load_last = (load_addr_q == ADDR_W'(LOAD_WORDS - 1));
  assign o_load_ready = (load_state_q == CSR_LOAD);

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      load_state_q <= CSR_IDLE;
      load_addr_q <= LOAD_START_ADDR;
    end else if (i_launch) begin
      // a relaunch mid-load restarts the image from the bottom
      load_state_q <= CSR_LOAD;
      load_addr_q <= LOAD_START_ADDR;
    end else begin
      case (load_state_q)
        CSR_IDLE: begin
          load_addr_q <= LOAD_START_ADDR;
        end
        CSR_LOAD: begin
          if (i_load_valid) begin
            if (load_last) begin
              load_state_q <= CSR_IDLE;
              load_addr_q <= LOAD_START_ADDR;
            end else begin
              load_addr_q <= load_addr_q + ADDR_W'(1);
            end
          end
        end
        default: begin
          load_state_q <= CSR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ram_wr_q.we <= 1'b0;
      ram_wr_q.addr <= LOAD_START_ADDR;
      ram_wr_q.data <= RST_WORD;
    end else begin
      ram_wr_q.we <= (load_state_q == CSR_LOAD) && i_load_valid && !i_launch;
      ram_wr_q.addr <= load_addr_q;
      ram_wr_q.data <= i_load_word;
    end
  end

  assign o_ram_wr = ram_wr_q;

  // core is held stopped from launch until its last word is accepted, on the same edge that issues that word's ram write
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      core_run_q <= 1'b0;
    end else if (i_launch) begin
      core_run_q <= 1'b0;
    end else if (load_state_q == CSR_LOAD && i_load_valid && load_last) begin
      core_run_q <= 1'b1;
    end
  end

  assign o_core_run = core_run_q;
endmodule // csr_core_regs

// *** design/csr_pkg.sv ***
// package of constants and carrier types for the core special register bank
package csr_pkg;
  // ---------------------------------------------------------------------
  // operand address map (register file addresses of the core)
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] ADDR_LAUNCH_PARAMETER = 9'h1F0;
  localparam logic [ADDR_W-1:0] ADDR_PIN_OUTPUT_LEVELS = 9'h1F4;
  localparam logic [ADDR_W-1:0] ADDR_SECOND_PORT_OUTPUT = 9'h1F5;
  localparam logic [ADDR_W-1:0] ADDR_COUNTER_A_PHASE = 9'h1FC;
  localparam logic [ADDR_W-1:0] ADDR_COUNTER_B_PHASE = 9'h1FD;

  // ---------------------------------------------------------------------
  // reset values and field layout
  // ---------------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
  localparam int LAUNCH_KEEP_LO = 2;
  localparam int LAUNCH_KEEP_HI = 15;
  localparam int LAUNCH_IN_W = 16;
  localparam logic [ADDR_W-1:0] LOAD_START_ADDR = 9'h000;
  localparam int LOAD_WORDS_DEF = 496;

  // ---------------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] src_addr;
    logic [ADDR_W-1:0] dst_addr;
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [DATA_W-1:0] wr_mask;
  } csr_op_t;

  typedef struct packed {
    logic src_hit;
    logic [DATA_W-1:0] src_data;
    logic dst_hit;
    logic [DATA_W-1:0] dst_data;
  } csr_rd_t;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } csr_ram_wr_t;

  typedef enum logic [0:0] {
    CSR_IDLE = 1'b0,
    CSR_LOAD = 1'b1
  } csr_load_state_t;
endpackage

// *** bench/csr_core_regs_checker.sv ***
// port assertions of the core special register bank
module csr_core_regs_checker #(
  parameter int LOAD_WORDS = csr_pkg::LOAD_WORDS_DEF
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire csr_pkg::csr_op_t i_op,
  input wire csr_pkg::csr_rd_t o_rd,
  input wire logic i_launch,
  input wire logic [15:0] i_launch_param,
  input wire logic i_load_valid,
  input wire logic [31:0] i_load_word,
  input wire logic o_load_ready,
  input wire csr_pkg::csr_ram_wr_t o_ram_wr,
  input wire logic [31:0] i_pin_dir,
  input wire logic [31:0] o_pin_oe,
  input wire logic [31:0] o_pin_level,
  input wire logic i_ctr_a_step,
  input wire logic [31:0] i_counter_a_increment
);
  timeunit 1ns / 100ps;
  import csr_pkg::*;
  logic [31:0] launch_q;
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) launch_q <= RST_WORD;
    else if (i_launch) launch_q <= {16'h0000, i_launch_param[15:2], 2'b00};
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  sequence pha_wr;
    i_op.wr_en && i_op.wr_addr == ADDR_COUNTER_A_PHASE && &i_op.wr_mask;
  endsequence
  pin_oe_a: assert property (o_pin_oe == i_pin_dir)
    else $error("pin enable wrong");
  pin_wr_a: assert property (i_op.wr_en &&
    i_op.wr_addr == ADDR_PIN_OUTPUT_LEVELS |=> o_pin_level ==
    (($past(o_pin_level) & ~$past(i_op.wr_mask)) |
    ($past(i_op.wr_data) & $past(i_op.wr_mask))))
    else $error("pin write wrong");
  rsvd_rd_a: assert property (i_op.src_addr ==
    ADDR_SECOND_PORT_OUTPUT |=> o_rd.src_hit && o_rd.src_data == 0)
    else $error("reserved read not zero");
  launch_rd_a: assert property (i_op.src_addr ==
    ADDR_LAUNCH_PARAMETER |=> o_rd.src_data == $past(launch_q))
    else $error("launch value wrong");
  pha_src_a: assert property (pha_wr ##1
    i_op.src_addr == ADDR_COUNTER_A_PHASE |=>
    o_rd.src_data == $past(i_op.wr_data, 2))
    else $error("phase write lost");
  pha_acc_a: assert property (i_op.src_addr ==
    ADDR_COUNTER_A_PHASE && i_ctr_a_step && !i_op.wr_en ##1
    i_op.src_addr == ADDR_COUNTER_A_PHASE |=> o_rd.src_data ==
    $past(o_rd.src_data) + $past(i_counter_a_increment, 2))
    else $error("phase not accumulating");
  load_first_a: assert property (i_launch ##1
    (i_load_valid && o_load_ready) |=>
    o_ram_wr.we && o_ram_wr.addr == LOAD_START_ADDR)
    else $error("load not at zero");
  load_data_a: assert property (i_load_valid && o_load_ready &&
    !i_launch |=> o_ram_wr.we && o_ram_wr.data == $past(i_load_word))
    else $error("loaded word wrong");
endmodule // csr_core_regs_checker
bind csr_core_regs csr_core_regs_checker #(.LOAD_WORDS(LOAD_WORDS)) i_chk (
  .i_clock(i_clock), .i_arst_n(i_arst_n), .i_op(i_op), .o_rd(o_rd),
  .i_launch(i_launch), .i_launch_param(i_launch_param),
  .i_load_valid(i_load_valid), .i_load_word(i_load_word),
  .o_load_ready(o_load_ready), .o_ram_wr(o_ram_wr), .i_pin_dir(i_pin_dir),
  .o_pin_oe(o_pin_oe), .o_pin_level(o_pin_level),
  .i_ctr_a_step(i_ctr_a_step),
  .i_counter_a_increment(i_counter_a_increment));

// *** bench/csr_code_src.sv ***
// behavioural code word source facing the launch loader
module csr_code_src #(
  parameter logic [31:0] SEED = 32'h0000_0000
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_restart,
  input wire logic i_stall,
  input wire logic i_ready,
  output logic o_valid,
  output logic [31:0] o_word
);
  timeunit 1ns / 100ps;
  int unsigned n;
  // a stalled line shows inverted data so a stale word cannot pass
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      n = 0;
      o_valid <= 1'b0;
      o_word <= 32'h0000_0000;
    end else begin
      if (o_valid && i_ready) n++;
      if (i_restart) n = 0;
      o_valid <= #1 !i_stall;
      o_word <= #1 i_stall ? ~o_word : SEED + n;
    end
  end
endmodule // csr_code_src

// *** bench/tb.sv ***
// self-checking bench of the core special register bank
module tb;
  timeunit 1ns / 100ps;
  import csr_pkg::*;
  localparam int NW = 4;
  localparam logic [31:0] SEED = 32'hC0DE_0000;
  logic clk = 1'b0, arst_n = 1'b1, launch = 1'b0, stall = 1'b0;
  logic valid, ready, run;
  logic [15:0] lparam = 16'h0000;
  logic [1:0] step = 2'b00;
  logic [31:0] inc [2] = '{32'h0000_0000, 32'h0000_0000};
  logic [31:0] dir = 32'hFFFF_0000;
  logic [31:0] word, level, oe;
  logic [8:0] a;
  csr_op_t op = '0;
  csr_rd_t rd;
  csr_ram_wr_t ram;
  int num_errors = 0, checked = 0, idx = 0, cycles = 0;
  csr_core_regs #(.LOAD_WORDS(NW)) i_dut (.i_clock(clk), .i_arst_n(arst_n),
    .i_op(op), .o_rd(rd), .i_launch(launch), .i_launch_param(lparam),
    .i_load_valid(valid), .i_load_word(word), .o_load_ready(ready),
    .o_ram_wr(ram), .o_core_run(run), .i_pin_dir(dir), .o_pin_level(level),
    .o_pin_oe(oe), .i_ctr_a_step(step[0]), .i_counter_a_increment(inc[0]),
    .i_ctr_b_step(step[1]), .i_counter_b_increment(inc[1]));
  csr_code_src #(.SEED(SEED)) i_src (.i_clock(clk), .i_arst_n(arst_n),
    .i_restart(launch), .i_stall(stall), .i_ready(ready), .o_valid(valid),
    .o_word(word));
  initial forever #2 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checked++;
    if (got !== want) begin
      num_errors++;
      $display("CHECK FAILED %0t: got %h want %h", $time, got, want);
    end
  endtask
  // source and destination both name the register, so one cycle
  // answers both operand slots
  task automatic acc(input logic [8:0] ad, input logic we,
      input logic [31:0] d, input logic [31:0] m);
    op = '{ad, ad, we, ad, d, m};
    @(posedge clk);
    #1;
  endtask
  task automatic rd2(input logic [8:0] ad, input logic [31:0] ws,
      input logic [31:0] wd);
    acc(ad, 1'b0, '0, '0);
    chk(rd.src_data, ws);
    chk(rd.dst_data, wd);
    chk({30'h0, rd.src_hit, rd.dst_hit}, 32'h3);
  endtask
  task automatic boot(input logic [15:0] p);
    lparam = p;
    launch = 1'b1;
    @(posedge clk);
    #1 launch = 1'b0;
    idx = 0;
  endtask
  task automatic fin;
    for (int n = 0; n < 40 && run !== 1'b1; n++) acc(9'h000, 1'b0, '0, '0);
    // the last word's ram write is counted one edge after run rises
    acc(9'h000, 1'b0, '0, '0);
    chk({31'h0, run}, 32'h1);
    chk(idx, NW);
    chk({31'h0, ready}, 32'h0);
  endtask
  task automatic close_out;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (ram.we === 1'b1) begin
      chk({23'h000, ram.addr}, idx);
      chk(ram.data, SEED + idx);
      idx++;
    end
    if (cycles == 3000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    arst_n = 1'b0;
    repeat (12) @(posedge clk);
    #1 arst_n = 1'b1;
    chk(level, RST_WORD);
    boot(16'hFFFF);
    stall = 1'b1;
    repeat (3) acc(9'h000, 1'b0, '0, '0);
    stall = 1'b0;
    fin();
    rd2(ADDR_LAUNCH_PARAMETER, 32'h0000_FFFC, 32'h0000_0000);
    boot(16'h0003);
    repeat (2) acc(9'h000, 1'b0, '0, '0);
    boot(16'h1236);
    fin();
    acc(ADDR_LAUNCH_PARAMETER, 1'b1, 32'hDEAD_BEEF, '1);
    rd2(ADDR_LAUNCH_PARAMETER, 32'h0000_1234, 32'hDEAD_BEEF);
    acc(ADDR_PIN_OUTPUT_LEVELS, 1'b1, 32'hA5A5_F00F, '1);
    chk(level, 32'hA5A5_F00F);
    chk(oe, dir);
    dir = 32'h0000_FFFF;
    acc(ADDR_PIN_OUTPUT_LEVELS, 1'b1, '1, 32'h0000_0FF0);
    chk(oe, dir);
    rd2(ADDR_PIN_OUTPUT_LEVELS, 32'hA5A5_FFFF, 32'hA5A5_FFFF);
    acc(ADDR_SECOND_PORT_OUTPUT, 1'b1, '1, '1);
    rd2(ADDR_SECOND_PORT_OUTPUT, '0, '0);
    for (int i = 0; i < 2; i++) begin
      a = i ? ADDR_COUNTER_B_PHASE : ADDR_COUNTER_A_PHASE;
      inc[i] = 32'h0000_0011 << i;
      acc(a, 1'b1, 32'hF000_0000, '1);
      step[i] = 1'b1;
      for (int k = 0; k < 3; k++) begin
        rd2(a, 32'hF000_0000 + k * inc[i], 32'hF000_0000);
      end
      step[i] = 1'b0;
      rd2(a, 32'hF000_0000 + 3 * inc[i], 32'hF000_0000);
      step[i] = 1'b1;
      acc(a, 1'b1, 32'h0000_0055, '1);
      step[i] = 1'b0;
      rd2(a, 32'h0000_0055, 32'h0000_0055);
    end
    close_out();
  end
endmodule // tb
